// File: pkg/amcr_map.svh
/*
 Constants for the mode control register bank: offsets, fields, reset values.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef AMCR_MAP_SVH
`define AMCR_MAP_SVH
`define AMCR_ADDR_RESET    7'h00
`define AMCR_ADDR_POWER    7'h01
`define AMCR_ADDR_CLOCKING 7'h02
`define AMCR_ADDR_OUTPUT   7'h03
`define AMCR_ADDR_FORMAT   7'h04
`define AMCR_RESET_BIT     7
`define AMCR_MASK_POWER    8'h03
`define AMCR_MASK_CLOCKING 8'h0F
`define AMCR_MASK_OUTPUT   8'h7F
`define AMCR_MASK_FORMAT   8'h3F
`define AMCR_REG_RESET     8'h00
`define AMCR_TP_OFF        3'h0
`define AMCR_TP_ZEROS      3'h1
`define AMCR_TP_ONES       3'h3
`define AMCR_TP_CHECKER    3'h5
`define AMCR_TP_ALTERNATE  3'h7
`define AMCR_CHECKER_WORD  13'h1555
`define AMCR_FRAME_BITS    5'h10
`define AMCR_TERM_NUM      5'h10
`define AMCR_TERM_DEN      5'h0A
`endif

// File: pkg/amcr_pkg.sv
/*
 Types for the mode control register bank.
 Assumes amcr_map.svh is on the include path.
*/
`include "amcr_map.svh"
package amcr_pkg;
   typedef enum logic [1:0] {
      AMCR_PWR_NORMAL = 2'h0,
      AMCR_PWR_NAP    = 2'h1,
      AMCR_PWR_UNUSED = 2'h2,
      AMCR_PWR_SLEEP  = 2'h3
   } amcr_power_t;

   typedef enum logic [2:0] {
      AMCR_ST_IDLE  = 3'h1,
      AMCR_ST_SHIFT = 3'h2,
      AMCR_ST_DONE  = 3'h4
   } amcr_state_t;

   // Decoded mode controls towards the converter core and pads
   typedef struct packed {
      logic [1:0] power_down_select;
      logic       nap_en;
      logic       sleep_en;
      logic       out_clock_invert;
      logic [1:0] out_clock_phase;
      logic       duty_cycle_stabilizer_en;
      logic [2:0] drive_current_select;
      logic       internal_term_en;
      logic [7:0] drive_current_tenth_ma;
      logic       output_disable;
      logic [1:0] output_format_select;
   } amcr_mode_t;

   // Converter sample: overflow plus twelve data bits
   typedef struct packed {
      logic        overflow_flag;
      logic [11:0] data;
   } amcr_sample_t;
endpackage : amcr_pkg

// File: logic/amcr_formatter.sv
/*
 Output data formatter: coding, scrambler, alternate polarity, test patterns,
 output disable. Assumes controls are static relative to samples.
*/
`timescale 1ns/10ps
`default_nettype none
`include "amcr_map.svh"
module amcr_formatter (
   input  wire logic                  clk_sys,
   input  wire logic                  srst,
   input  wire amcr_pkg::amcr_sample_t sampleIn,
   input  wire logic [2:0]            testPatternSelect,
   input  wire logic                  altBitPolarityEn,
   input  wire logic                  outputScramblerEn,
   input  wire logic                  signedCodingSel,
   input  wire logic                  outputDisable,
   output logic [12:0]                dataOut,
   output logic                       dataOutEnN
);
   logic        phase_r;
   logic        phase_nxt;
   logic [12:0] data_r;
   logic [12:0] data_nxt;
   logic        en_r;
   logic        en_nxt;
   logic [11:0] work;

   // Next sample word; pattern path last since it wins
   always_comb begin
      work = sampleIn.data;
      phase_nxt = ~phase_r;
      if (signedCodingSel && !altBitPolarityEn) begin
         work[11] = ~work[11];
      end
      if (outputScramblerEn) begin
         work[11:1] = work[11:1] ^ {11{work[0]}};
      end
      if (altBitPolarityEn) begin
         work = work ^ 12'hAAA;
      end
      data_nxt = {sampleIn.overflow_flag, work};
      case (testPatternSelect)
         `AMCR_TP_ZEROS:     data_nxt = 13'h0000;
         `AMCR_TP_ONES:      data_nxt = 13'h1FFF;
         `AMCR_TP_CHECKER:   data_nxt = phase_r ? ~`AMCR_CHECKER_WORD : `AMCR_CHECKER_WORD;
         `AMCR_TP_ALTERNATE: data_nxt = phase_r ? 13'h1FFF : 13'h0000;
         default: ;
      endcase
      en_nxt = outputDisable;
   end

   // Sample registers; pad drivers tristate when enable is high
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         phase_r <= 1'b0;
         data_r  <= 13'h0000;
         en_r    <= 1'b1;
      end else begin
         phase_r <= phase_nxt;
         data_r  <= data_nxt;
         en_r    <= en_nxt;
      end
   end

   assign dataOut    = data_r;
   assign dataOutEnN = en_r;
endmodule : amcr_formatter
`default_nettype wire

// File: logic/amcr_mode_regs.sv
/*
 Mode control register bank behind the serial configuration port, plus the
 decoded controls and the output formatter. Assumes the serial pins arrive
 asynchronously and the port clock runs well below clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
`include "amcr_map.svh"
module amcr_mode_regs (
   input  wire logic                  clk_sys,
   input  wire logic                  srst,
   input  wire logic                  cfgSelN,
   input  wire logic                  cfgSck,
   input  wire logic                  cfgSdi,
   output logic                       cfgSdoOut,
   output logic                       cfgSdoOeN,
   input  wire amcr_pkg::amcr_sample_t sampleIn,
   output amcr_pkg::amcr_mode_t        modeCtl,
   output logic                       outputClock,
   output logic                       outputClockEnN,
   output logic [12:0]                dataOut,
   output logic                       dataOutEnN
);
   // Write mask per address; unknown addresses mask all bits
   function automatic logic [7:0] wmask(input logic [6:0] a);
      case (a)
         `AMCR_ADDR_POWER:    wmask = `AMCR_MASK_POWER;
         `AMCR_ADDR_CLOCKING: wmask = `AMCR_MASK_CLOCKING;
         `AMCR_ADDR_OUTPUT:   wmask = `AMCR_MASK_OUTPUT;
         `AMCR_ADDR_FORMAT:   wmask = `AMCR_MASK_FORMAT;
         default:             wmask = 8'h00;
      endcase
   endfunction : wmask

   logic [2:0] selSync_r;
   logic [2:0] sckSync_r;
   logic [2:0] sdiSync_r;
   logic       sel_r;
   logic       sck_r;
   logic       sdi_r;
   logic       sel_nxt;
   logic       sck_nxt;
   logic       sdi_nxt;
   amcr_pkg::amcr_state_t state_r;
   amcr_pkg::amcr_state_t state_nxt;
   logic [15:0] shift_r;
   logic [15:0] shift_nxt;
   logic [4:0]  count_r;
   logic [4:0]  count_nxt;
   logic [7:0]  regs_r [1:4];
   logic [7:0]  regs_nxt [1:4];
   logic        rstPend_r;
   logic        rstPend_nxt;
   logic [7:0]  rdData_r;
   logic [7:0]  rdData_nxt;
   logic        sdo_r;
   logic        sdo_nxt;
   logic        sckRise;
   logic        sckFall;
   logic [6:0]  addr;

   // Three-stage synchronisers; stage one feeds only stage two
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         selSync_r <= 3'h7;
         sckSync_r <= 3'h0;
         sdiSync_r <= 3'h0;
         sel_r     <= 1'b1;
         sck_r     <= 1'b0;
         sdi_r     <= 1'b0;
      end else begin
         selSync_r <= {selSync_r[1:0], cfgSelN};
         sckSync_r <= {sckSync_r[1:0], cfgSck};
         sdiSync_r <= {sdiSync_r[1:0], cfgSdi};
         sel_r     <= sel_nxt;
         sck_r     <= sck_nxt;
         sdi_r     <= sdi_nxt;
      end
   end

   // Accept a level change once stages two and three agree
   always_comb begin
      sel_nxt = (selSync_r[2] == selSync_r[1]) ? selSync_r[2] : sel_r;
      sck_nxt = (sckSync_r[2] == sckSync_r[1]) ? sckSync_r[2] : sck_r;
      sdi_nxt = (sdiSync_r[2] == sdiSync_r[1]) ? sdiSync_r[2] : sdi_r;
   end

   assign sckRise = sck_nxt & ~sck_r;
   assign sckFall = ~sck_nxt & sck_r;
   assign addr    = shift_r[14:8];

   // Frame engine: 16 bits, read/write flag first, then address and data
   always_comb begin
      state_nxt   = state_r;
      shift_nxt   = shift_r;
      count_nxt   = count_r;
      rstPend_nxt = rstPend_r;
      rdData_nxt  = rdData_r;
      sdo_nxt     = sdo_r;
      for (int i = 1; i <= 4; i++) begin
         regs_nxt[i] = regs_r[i];
      end
      case (state_r)
         amcr_pkg::AMCR_ST_IDLE: begin
            sdo_nxt = 1'b1;
            if (!sel_r) begin
               count_nxt = 5'h00;
               state_nxt = amcr_pkg::AMCR_ST_SHIFT;
            end
         end
         amcr_pkg::AMCR_ST_SHIFT: begin
            // Extra edges past sixteen are ignored
            if (sckRise && count_r < `AMCR_FRAME_BITS) begin
               shift_nxt = {shift_r[14:0], sdi_r};
               count_nxt = count_r + 5'h01;
               if (count_r == 5'h07) begin
                  // Read data captured once the address is in
                  case ({shift_r[5:0], sdi_r})
                     `AMCR_ADDR_POWER:    rdData_nxt = regs_r[1];
                     `AMCR_ADDR_CLOCKING: rdData_nxt = regs_r[2];
                     `AMCR_ADDR_OUTPUT:   rdData_nxt = regs_r[3];
                     `AMCR_ADDR_FORMAT:   rdData_nxt = regs_r[4];
                     default:             rdData_nxt = 8'h00;
                  endcase
               end
            end
            // Read data driven on falling edges after the address
            // Read flag climbs one place per bit, so index it by the count
            if (sckFall && shift_r[4'(count_r - 5'h01)] && count_r >= 5'h08
                && count_r < `AMCR_FRAME_BITS) begin
               sdo_nxt    = rdData_r[7];
               rdData_nxt = {rdData_r[6:0], 1'b0};
            end
            if (sel_r) begin
               state_nxt = amcr_pkg::AMCR_ST_DONE;
            end
         end
         amcr_pkg::AMCR_ST_DONE: begin
            sdo_nxt   = 1'b1;
            state_nxt = amcr_pkg::AMCR_ST_IDLE;
            // Commit only full write frames
            if (count_r == `AMCR_FRAME_BITS && !shift_r[15]) begin
               if (addr == `AMCR_ADDR_RESET) begin
                  rstPend_nxt = shift_r[`AMCR_RESET_BIT];
               end else begin
                  for (int i = 1; i <= 4; i++) begin
                     if (addr == 7'(i)) begin
                        regs_nxt[i] = shift_r[7:0] & wmask(addr);
                     end
                  end
               end
            end
         end
         default: state_nxt = amcr_pkg::AMCR_ST_IDLE;
      endcase
      if (rstPend_r) begin
         for (int i = 1; i <= 4; i++) begin
            regs_nxt[i] = `AMCR_REG_RESET;
         end
         rstPend_nxt = 1'b0;
      end
   end

   // Frame and register state
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_r   <= amcr_pkg::AMCR_ST_IDLE;
         shift_r   <= 16'h0000;
         count_r   <= 5'h00;
         rstPend_r <= 1'b0;
         rdData_r  <= 8'h00;
         sdo_r     <= 1'b1;
         for (int i = 1; i <= 4; i++) begin
            regs_r[i] <= `AMCR_REG_RESET;
         end
      end else begin
         state_r   <= state_nxt;
         shift_r   <= shift_nxt;
         count_r   <= count_nxt;
         rstPend_r <= rstPend_nxt;
         rdData_r  <= rdData_nxt;
         sdo_r     <= sdo_nxt;
         for (int i = 1; i <= 4; i++) begin
            regs_r[i] <= regs_nxt[i];
         end
      end
   end

   // Open drain: drive low only, enable low while pulling
   assign cfgSdoOut = 1'b0;
   assign cfgSdoOeN = sdo_r;

   // Decoded controls; 16/10 gives the 1.6x termination boost
   always_comb begin
      modeCtl.power_down_select = regs_r[1][1:0];
      modeCtl.nap_en   = (regs_r[1][1:0] == amcr_pkg::AMCR_PWR_NAP);
      modeCtl.sleep_en = (regs_r[1][1:0] == amcr_pkg::AMCR_PWR_SLEEP);
      modeCtl.out_clock_invert         = regs_r[2][3];
      modeCtl.out_clock_phase          = regs_r[2][2:1];
      modeCtl.duty_cycle_stabilizer_en = regs_r[2][0];
      modeCtl.drive_current_select     = regs_r[3][6:4];
      modeCtl.internal_term_en         = regs_r[3][3];
      // drive current decode, tenths of mA
      case (regs_r[3][6:4])
         3'h0:    modeCtl.drive_current_tenth_ma = 8'h23;
         3'h1:    modeCtl.drive_current_tenth_ma = 8'h28;
         3'h2:    modeCtl.drive_current_tenth_ma = 8'h2D;
         3'h4:    modeCtl.drive_current_tenth_ma = 8'h1E;
         3'h5:    modeCtl.drive_current_tenth_ma = 8'h19;
         3'h6:    modeCtl.drive_current_tenth_ma = 8'h15;
         3'h7:    modeCtl.drive_current_tenth_ma = 8'h11;
         default: modeCtl.drive_current_tenth_ma = 8'h23;
      endcase
      if (regs_r[3][3]) begin
         modeCtl.drive_current_tenth_ma = 8'((16'(modeCtl.drive_current_tenth_ma)
            * 16'(`AMCR_TERM_NUM)) / 16'(`AMCR_TERM_DEN));
      end
      modeCtl.output_disable       = regs_r[3][2];
      modeCtl.output_format_select = regs_r[3][1:0];
   end

   assign outputClock    = clk_sys ^ regs_r[2][3];
   assign outputClockEnN = regs_r[3][2];

   amcr_formatter u_formatter (
      .clk_sys           (clk_sys),
      .srst              (srst),
      .sampleIn          (sampleIn),
      .testPatternSelect (regs_r[4][5:3]),
      .altBitPolarityEn  (regs_r[4][2]),
      .outputScramblerEn (regs_r[4][1]),
      .signedCodingSel   (regs_r[4][0]),
      .outputDisable     (regs_r[3][2]),
      .dataOut           (dataOut),
      .dataOutEnN        (dataOutEnN)
   );
endmodule : amcr_mode_regs
`default_nettype wire

// File: tb/amcr_host_model.sv
/*
 Host controller model driving the serial configuration port.
 Assumes a pull-up on SDO and clk_sys as its time base.
*/
`timescale 1ns/10ps
`default_nettype none
module amcr_host_model (
   input  wire logic clk_sys,
   output logic      cfgSelN,
   output logic      cfgSck,
   output logic      cfgSdi,
   input  wire logic cfgSdo
);
   int halfClk = 6; // SCK half period in clocks, raised for slow frames

   // Idle port: select high, serial clock parked low
   initial begin
      cfgSelN = 1'b1;
      cfgSck = 1'b0;
      cfgSdi = 1'b0;
   end

   // One 16-bit frame, MSB first; readback taken just before each of the last eight rising SCK edges
   task automatic xfer(input logic rd, input logic [6:0] addr,
                       input logic [7:0] wdata, output logic [7:0] rdata);
      logic [15:0] word;
      word = {rd, addr, wdata};
      rdata = 8'h00;
      @(posedge clk_sys) #1 cfgSelN = 1'b0;
      repeat (4) @(posedge clk_sys);
      for (int i = 15; i >= 0; i--) begin
         #1 cfgSck = 1'b0;
         cfgSdi = word[i];
         repeat (halfClk) @(posedge clk_sys);
         #1 if (i < 8) rdata[i[2:0]] = cfgSdo;
         cfgSck = 1'b1;
         repeat (halfClk) @(posedge clk_sys);
      end
      #1 cfgSck = 1'b0;
      cfgSdi = ~cfgSdi; // Released data line does not keep its last value
      repeat (halfClk) @(posedge clk_sys);
      #1 cfgSelN = 1'b1;
      repeat (10) @(posedge clk_sys);
      #1;
   endtask : xfer
endmodule : amcr_host_model
`default_nettype wire

// File: tb/amcr_mode_regs_assertions.sv
/*
 Port checker for the mode control register bank.
 Assumes binding to amcr_mode_regs and a clean clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
module amcr_checker (
   input wire logic                 clk_sys,
   input wire logic                 srst,
   input wire logic                 cfgSelN,
   input wire logic                 cfgSdoOeN,
   input wire amcr_pkg::amcr_mode_t modeCtl,
   input wire logic                 outputClock,
   input wire logic                 outputClockEnN,
   input wire logic                 dataOutEnN
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   // Power code decode
   a_nap_decode: assert property (modeCtl.nap_en == (modeCtl.power_down_select == 2'h1))
      else $error("nap flag does not follow power code");
   a_sleep_decode: assert property (modeCtl.sleep_en == (modeCtl.power_down_select == 2'h3))
      else $error("sleep flag does not follow power code");
   // Clock sampled high at the falling edge, so output shows the invert bit's complement
   a_clock_invert: assert property (@(negedge clk_sys) outputClock == !modeCtl.out_clock_invert)
      else $error("output clock polarity wrong");
   // Clock pad floats with the disable bit, data pad one clk_sys cycle later
   a_clock_tristate: assert property (outputClockEnN == modeCtl.output_disable)
      else $error("clock pad enable wrong");
   a_data_tristate: assert property (!$past(srst) |-> dataOutEnN == $past(modeCtl.output_disable))
      else $error("data pad enable wrong");
   // Drive current figures in tenths of a milliamp
   a_drive_base: assert property (modeCtl.drive_current_select == 3'h0 && !modeCtl.internal_term_en
      |-> modeCtl.drive_current_tenth_ma == 8'h23)
      else $error("base drive current wrong");
   a_term_scale: assert property (modeCtl.drive_current_select == 3'h0 && modeCtl.internal_term_en
      |-> modeCtl.drive_current_tenth_ma == 8'h38)
      else $error("terminated drive current wrong");
   a_drive_lowest: assert property (modeCtl.drive_current_select == 3'h7 && !modeCtl.internal_term_en
      |-> modeCtl.drive_current_tenth_ma == 8'h11)
      else $error("lowest drive current wrong");
   // Open drain must be released once the select has been high a while
   a_sdo_quiet: assert property (cfgSelN [*8] |-> cfgSdoOeN)
      else $error("serial output held while deselected");

   c_sleep: cover property (modeCtl.sleep_en);
   c_term: cover property (modeCtl.internal_term_en && modeCtl.drive_current_select == 3'h6);
   c_readback: cover property (!cfgSdoOeN);
   c_float: cover property ($rose(dataOutEnN));
endmodule : amcr_checker

bind amcr_mode_regs amcr_checker i_amcr_checker (
   .clk_sys(clk_sys),
   .srst(srst),
   .cfgSelN(cfgSelN),
   .cfgSdoOeN(cfgSdoOeN),
   .modeCtl(modeCtl),
   .outputClock(outputClock),
   .outputClockEnN(outputClockEnN),
   .dataOutEnN(dataOutEnN)
);
`default_nettype wire

// File: tb/testbench.sv
/*
 Self-checking bench for the mode control register bank.
 Assumes the host model and checker are compiled alongside.
*/
`timescale 1ns/10ps
`default_nettype none
`include "amcr_map.svh"
module testbench;
   logic                   clk_sys = 1'b0;
   logic                   srst = 1'b1;
   logic                   cfgSelN, cfgSck, cfgSdi, cfgSdoOut, cfgSdoOeN;
   logic                   outputClock, outputClockEnN, dataOutEnN;
   wire logic              sdoWire;
   amcr_pkg::amcr_sample_t sampleIn = 13'h0000;
   amcr_pkg::amcr_mode_t   modeCtl;
   logic [12:0]            dataOut, d0;
   logic [7:0]             rd;
   int                     errors = 0;
   int                     samples_checked = 0;
   logic [7:0]  cur [8] = '{8'h23, 8'h28, 8'h2D, 8'h23, 8'h1E, 8'h19, 8'h15, 8'h11};
   logic [12:0] smp [2] = '{13'h1A53, 13'h0801};
   logic [2:0]  tp [4] = '{`AMCR_TP_ZEROS, `AMCR_TP_ONES, `AMCR_TP_CHECKER, `AMCR_TP_ALTERNATE};
   logic [12:0] xr [4] = '{13'h0000, 13'h0000, 13'h1FFF, 13'h1FFF};
   logic [11:0] adj [4] = '{12'h000, 12'h000, 12'hFFF, 12'h000};

   always #2.5 clk_sys = ~clk_sys;
   assign sdoWire = cfgSdoOeN ? 1'b1 : cfgSdoOut; // Pull-up on the open drain

   amcr_mode_regs i_amcr_mode_regs (.clk_sys(clk_sys), .srst(srst), .cfgSelN(cfgSelN),
      .cfgSck(cfgSck), .cfgSdi(cfgSdi), .cfgSdoOut(cfgSdoOut), .cfgSdoOeN(cfgSdoOeN),
      .sampleIn(sampleIn), .modeCtl(modeCtl), .outputClock(outputClock),
      .outputClockEnN(outputClockEnN), .dataOut(dataOut), .dataOutEnN(dataOutEnN));
   amcr_host_model i_amcr_host_model (.clk_sys(clk_sys), .cfgSelN(cfgSelN), .cfgSck(cfgSck),
      .cfgSdi(cfgSdi), .cfgSdo(sdoWire));

   task automatic check(input logic [12:0] got, input logic [12:0] exp, input string msg);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : check

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      i_amcr_host_model.xfer(1'b0, a, d, rd);
   endtask : wr

   task automatic rchk(input logic [6:0] a, input logic [7:0] e);
      i_amcr_host_model.xfer(1'b1, a, 8'hA5, rd);
      check({5'h00, rd}, {5'h00, e}, "readback");
   endtask : rchk

   // Expected coding: sign flip unless polarity mode, scramble, odd-bit flip
   function automatic logic [12:0] fmt(input logic [12:0] s, input logic [2:0] f);
      logic [11:0] d;
      d = s[11:0];
      if (f[0] && !f[2]) d[11] = ~d[11];
      if (f[1]) d[11:1] = d[11:1] ^ {11{d[0]}};
      if (f[2]) d = d ^ 12'hAAA;
      return {s[12], d};
   endfunction : fmt

   task automatic test_done();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   // Main sequence
   initial begin
      repeat (12) @(posedge clk_sys);
      #1 srst = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1 check({12'h000, dataOutEnN}, 13'h0000, "enable");
      wr(`AMCR_ADDR_RESET, 8'h80);
      wr(`AMCR_ADDR_POWER, 8'hFF);
      wr(`AMCR_ADDR_CLOCKING, 8'hFF);
      wr(`AMCR_ADDR_OUTPUT, 8'hFB);
      wr(`AMCR_ADDR_FORMAT, 8'hC7);
      wr(7'h05, 8'hFF);
      rchk(`AMCR_ADDR_POWER, 8'h03);
      rchk(`AMCR_ADDR_CLOCKING, 8'h0F);
      rchk(`AMCR_ADDR_OUTPUT, 8'h7B);
      rchk(`AMCR_ADDR_FORMAT, 8'h07);
      rchk(7'h05, 8'h00);
      rchk(`AMCR_ADDR_RESET, 8'h00);
      check({11'h000, outputClock, modeCtl.duty_cycle_stabilizer_en}, 13'h0001, "clk");
      // Slow frame for the mid-run soft reset
      i_amcr_host_model.halfClk = 10;
      wr(`AMCR_ADDR_RESET, 8'h80);
      i_amcr_host_model.halfClk = 6;
      for (int a = 1; a < 5; a++) rchk(7'(a), 8'h00);
      check({11'h000, outputClock, modeCtl.duty_cycle_stabilizer_en}, 13'h0002, "clk");
      for (int p = 0; p < 4; p++) begin
         wr(`AMCR_ADDR_POWER, 8'(p));
         check({11'h000, modeCtl.nap_en, modeCtl.sleep_en}, {11'h000, p == 1, p == 3}, "pwr");
      end
      for (int k = 0; k < 15; k++) begin
         wr(`AMCR_ADDR_OUTPUT, {1'b0, 3'(k % 8), k > 7, 3'h0});
         check(13'(modeCtl.drive_current_tenth_ma),
               13'(k > 7 ? cur[k % 8] * 16 / 10 : cur[k % 8]), "drive");
      end
      wr(`AMCR_ADDR_OUTPUT, 8'h04);
      check({11'h000, dataOutEnN, outputClockEnN}, 13'h0003, "hi-z");
      wr(`AMCR_ADDR_OUTPUT, 8'h00);
      check({11'h000, dataOutEnN, outputClockEnN}, 13'h0000, "driven");
      for (int f = 0; f < 8; f++) begin
         wr(`AMCR_ADDR_FORMAT, 8'(f));
         foreach (smp[j]) begin
            @(posedge clk_sys) #1 sampleIn = smp[j];
            repeat (2) @(posedge clk_sys);
            #1 check(dataOut, fmt(smp[j], 3'(f)), "format");
         end
      end
      // Patterns with every formatting option also on
      for (int t = 0; t < 4; t++) begin
         wr(`AMCR_ADDR_FORMAT, {2'h0, tp[t], 3'h7});
         d0 = dataOut;
         @(posedge clk_sys) #1;
         check(d0 ^ dataOut, xr[t], "pattern step");
         check({1'b0, d0[12:1] ^ d0[11:0]}, {1'b0, adj[t]}, "pattern bits");
         if (t < 2) check(d0, {13{t[0]}}, "pattern level");
      end
      test_done();
   end

   // Watchdog against a hung frame
   initial begin
      repeat (40000) @(posedge clk_sys);
      errors++;
      $display("FAIL %0t watchdog expired", $time);
      test_done();
   end
endmodule : testbench
`default_nettype wire
